// >>> rtl/gpc_regs_map.svh
// offsets, field positions and fixed values of the graphics port capability words
`ifndef GPC_REGS_MAP_SVH
`define GPC_REGS_MAP_SVH

// word offsets from the capability base
`define GPC_ID_OFF 8'h00
`define GPC_STAT_OFF 8'h04
`define GPC_CMD_OFF 8'h08

// identifier word fields
`define GPC_CAP_CODE 8'h02
`define GPC_CODE_LSB 0
`define GPC_LINK_LSB 8
`define GPC_MINOR_LSB 16
`define GPC_MAJOR_LSB 20

// status and command field positions, enable bit in the command word only
`define GPC_DEPTH_LSB 24
`define GPC_SIDEBAND_BIT 9
`define GPC_ENABLE_BIT 8
`define GPC_HIGH_BIT 5
`define GPC_FAST_BIT 4
`define GPC_RATE_LSB 0

// reset value of the command word
`define GPC_CMD_RST 32'h0000_0000

`endif

// >>> rtl/gpc_pkg.sv
// types shared by the graphics port capability register set
`default_nettype none
package gpc_pkg;

    // role of the function on the port, one-hot coded
    typedef enum logic [1:0] {
        GPC_ROLE_TARGET = 2'h1,
        GPC_ROLE_MASTER = 2'h2
    } gpc_role_type;

    // incoming operation kinds seen by a target
    typedef enum logic [1:0] {
        GPC_OP_PLAIN = 2'h0,
        GPC_OP_DUAL_ADDR = 2'h1,
        GPC_OP_SIDEBAND_T4 = 2'h2,
        GPC_OP_SIDEBAND_T3 = 2'h3
    } gpc_op_type;

endpackage : gpc_pkg
`default_nettype wire

// >>> rtl/gpc_cap_regs.sv
// capability identifier, status and command words of a graphics port function
`timescale 1ns/10ps
`default_nettype none
`include "gpc_regs_map.svh"

// Function
// [RQ1] identifier low byte reads fixed code 02h
// [RQ2] bits 15:8 give next entry link
// [RQ3] major and minor revision, read only
// [RQ4] identifier top byte reads zero, unwritable
// [RQ5] status 31:24 reports queue capacity minus one
// [RQ6] status bit 9 flags sideband support
// [RQ7] status bit 5 flags high address support
// [RQ8] status bit 4 flags fast write support
// [RQ9] status 2:0 report all supported rates
// [RQ10] status word read only, reserved reads zero
// [RQ11] master command 31:24 holds allowed depth
// [RQ12] target treats depth field as reserved
// [RQ13] command bit 9 enables sideband addressing
// [RQ14] master initiates only while bit 8 set
// [RQ15] target accepts only while bit 8 set
// [RQ16] software configures target before the master
// [RQ17] enable set last or in one write
// [RQ18] master high addresses only with bit 5
// [RQ19] target bit 5 selects dual or sideband forms
// [RQ20] reserved command bits read zero, unwritable
// [RQ21] exactly one rate bit selected, matching ends; the code stores any 3-bit value written to 2:0 unchecked
// [RQ22] bit 4 selects fast write for writes
// [RQ23] command word clears to zero at reset
module gpc_cap_regs #(
    parameter gpc_pkg::gpc_role_type ROLE = gpc_pkg::GPC_ROLE_TARGET,
    parameter logic [7:0] CAP_BASE = 8'h40,
    parameter logic [7:0] LIST_LINK = 8'h00,
    parameter logic [3:0] REV_MAJOR = 4'h2,
    parameter logic [3:0] REV_MINOR = 4'h0,
    parameter logic [7:0] QUEUE_CAPACITY = 8'h1F,
    parameter logic SIDEBAND_SUPPORTED = 1'b1,
    parameter logic HIGH_ADDRESS_FLAG = 1'b1,
    parameter logic FAST_WRITE_SUPPORTED = 1'b1,
    parameter logic [2:0] RATES_SUPPORTED = 3'h7
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // configuration access
    input wire logic cfg_rd_in,
    input wire logic cfg_wr_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [3:0] cfg_be_in,
    input wire logic [31:0] cfg_wdata_in,
    output logic cfg_ack_out,
    output logic [31:0] cfg_rdata_out,
    // master side requests from the core
    input wire logic mst_op_req_in,
    input wire logic mst_high_addr_in,
    output logic mst_op_start_out,
    // target side incoming operations
    input wire logic tgt_op_valid_in,
    input wire gpc_pkg::gpc_op_type tgt_op_kind_in,
    output logic tgt_op_accept_out,
    output logic tgt_upper_addr_out,
    // programmed modes to the port logic
    output logic port_operation_on_out,
    output logic sideband_on_out,
    output logic high_address_on_out,
    output logic fast_write_on_out,
    output logic [2:0] rate_select_out,
    output logic [7:0] allowed_queue_depth_out
);

    // ------------------------------------------------------------
    // address decode and fixed words
    // ------------------------------------------------------------

    // access hits, one per word
    wire logic [7:0] word_addr = {cfg_addr_in[7:2], 2'h0};
    wire logic hit_id = (word_addr == 8'(CAP_BASE + `GPC_ID_OFF));
    wire logic hit_stat = (word_addr == 8'(CAP_BASE + `GPC_STAT_OFF));
    wire logic hit_cmd = (word_addr == 8'(CAP_BASE + `GPC_CMD_OFF));
    wire logic is_master = (ROLE == gpc_pkg::GPC_ROLE_MASTER);

    // identifier word, top byte zero
    wire logic [31:0] id_word = {8'h00, REV_MAJOR, REV_MINOR, LIST_LINK, // RQ4 RQ3 RQ2
                                 8'(`GPC_CAP_CODE)}; // RQ1

    // status word, constant, reserved bits zero
    wire logic [31:0] stat_word = {QUEUE_CAPACITY, 14'h0000, // RQ5
                                   SIDEBAND_SUPPORTED, 3'h0, // RQ6
                                   HIGH_ADDRESS_FLAG, // RQ7
                                   FAST_WRITE_SUPPORTED, 1'b0, // RQ8
                                   RATES_SUPPORTED}; // RQ9

    // ------------------------------------------------------------
    // command word storage
    // ------------------------------------------------------------

    logic [7:0] depth_q;
    logic sideband_q;
    logic enable_q;
    logic high_q;
    logic fast_q;
    logic [2:0] rate_q;

    // write strobes for byte lanes 0, 1 and 3 of the command word
    wire logic cmd_wr = cfg_wr_in & hit_cmd;
    wire logic wr_b0 = cmd_wr & cfg_be_in[0];
    wire logic wr_b1 = cmd_wr & cfg_be_in[1];
    wire logic wr_b3 = cmd_wr & cfg_be_in[3] & is_master; // RQ12

    // next values, only implemented bits are taken
    wire logic [7:0] depth_d = wr_b3 ? cfg_wdata_in[31:24] : depth_q; // RQ11
    wire logic sideband_d = wr_b1 ? cfg_wdata_in[`GPC_SIDEBAND_BIT] : sideband_q; // RQ13
    wire logic enable_d = wr_b1 ? cfg_wdata_in[`GPC_ENABLE_BIT] : enable_q; // RQ17
    wire logic high_d = wr_b0 ? cfg_wdata_in[`GPC_HIGH_BIT] : high_q;
    wire logic fast_d = wr_b0 ? cfg_wdata_in[`GPC_FAST_BIT] : fast_q; // RQ22
    wire logic [2:0] rate_d = wr_b0 ? cfg_wdata_in[2:0] : rate_q; // RQ21

    // command fields, all cleared at reset
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            {depth_q, sideband_q, enable_q} <= 10'h000; // RQ23
            {high_q, fast_q, rate_q} <= 5'h00;
        end
        else
        begin
            {depth_q, sideband_q, enable_q} <= {depth_d, sideband_d, enable_d};
            {high_q, fast_q, rate_q} <= {high_d, fast_d, rate_d};
        end
    end

    // command word as read back, reserved bits zero
    wire logic [31:0] cmd_word = {depth_q, 14'h0000, sideband_q, enable_q, // RQ20
                                  2'h0, high_q, fast_q, 1'b0, rate_q};

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------

    // read data select, unmapped words read zero
    wire logic [31:0] rd_sel = hit_id ? id_word :
                               hit_stat ? stat_word : // RQ10
                               hit_cmd ? cmd_word : 32'h0000_0000;

    logic ack_q;
    logic [31:0] rdata_q;

    // one cycle answer to every access
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= cfg_rd_in | cfg_wr_in;
            rdata_q <= cfg_rd_in ? rd_sel : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // operation gating
    // ------------------------------------------------------------

    // master start allowed only when enabled and in range
    wire logic mst_go = is_master & enable_q & mst_op_req_in & // RQ14
                        (~mst_high_addr_in | high_q); // RQ18

    // target accepts each kind according to mode bits
    wire logic kind_ok = (tgt_op_kind_in == gpc_pkg::GPC_OP_PLAIN) |
                         ((tgt_op_kind_in == gpc_pkg::GPC_OP_DUAL_ADDR) & high_q & ~sideband_q) |
                         ((tgt_op_kind_in == gpc_pkg::GPC_OP_SIDEBAND_T4) & high_q & sideband_q) |
                         ((tgt_op_kind_in == gpc_pkg::GPC_OP_SIDEBAND_T3) & sideband_q); // RQ19
    wire logic tgt_go = ~is_master & enable_q & tgt_op_valid_in & kind_ok; // RQ15
    wire logic tgt_upper = tgt_go & high_q & sideband_q &
                           (tgt_op_kind_in == gpc_pkg::GPC_OP_SIDEBAND_T3); // RQ19

    logic mst_start_q;
    logic tgt_accept_q;
    logic tgt_upper_q;

    // operation strobes
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            {mst_start_q, tgt_accept_q, tgt_upper_q} <= 3'h0;
        end
        else
        begin
            {mst_start_q, tgt_accept_q, tgt_upper_q} <= {mst_go, tgt_go, tgt_upper};
        end
    end

    // outputs straight from flops
    assign cfg_ack_out = ack_q;
    assign cfg_rdata_out = rdata_q;
    assign mst_op_start_out = mst_start_q;
    assign tgt_op_accept_out = tgt_accept_q;
    assign tgt_upper_addr_out = tgt_upper_q;
    assign port_operation_on_out = enable_q;
    assign sideband_on_out = sideband_q;
    assign high_address_on_out = high_q;
    assign fast_write_on_out = fast_q;
    assign rate_select_out = rate_q;
    assign allowed_queue_depth_out = depth_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------

    id_code_read_a: // RQ1
    assert property (@(posedge mclk_in) disable iff (rst_in)
        cfg_rd_in & hit_id |=> cfg_ack_out && cfg_rdata_out[7:0] == 8'h02 &&
        cfg_rdata_out[15:8] == LIST_LINK) // RQ2
        else $error("identifier code or link wrong");

    id_top_zero_a: // RQ4
    assert property (@(posedge mclk_in) disable iff (rst_in)
        cfg_rd_in & hit_id |=> cfg_rdata_out[31:24] == 8'h00 &&
        cfg_rdata_out[23:16] == {REV_MAJOR, REV_MINOR}) // RQ3
        else $error("identifier top byte or revision wrong");

    status_fixed_a: // RQ10
    assert property (@(posedge mclk_in) disable iff (rst_in)
        cfg_rd_in & hit_stat |=> cfg_rdata_out == {QUEUE_CAPACITY, 14'h0000,
        SIDEBAND_SUPPORTED, 3'h0, HIGH_ADDRESS_FLAG, FAST_WRITE_SUPPORTED, 1'b0,
        RATES_SUPPORTED}) // RQ5
        else $error("status word not as fixed");

    cmd_reserved_zero_a: // RQ20
    assert property (@(posedge mclk_in) disable iff (rst_in)
        cfg_rd_in & hit_cmd |=> cfg_rdata_out[23:10] == 14'h0000 &&
        cfg_rdata_out[7:6] == 2'h0 && cfg_rdata_out[3] == 1'b0)
        else $error("reserved command bits not zero");

    cmd_enable_write_a: // RQ17
    assert property (@(posedge mclk_in) disable iff (rst_in)
        cfg_wr_in & hit_cmd & cfg_be_in[1] |=>
        port_operation_on_out == $past(cfg_wdata_in[8]) &&
        sideband_on_out == $past(cfg_wdata_in[9])) // RQ13
        else $error("enable or sideband not written");

    target_depth_reserved_a: // RQ12
    assert property (@(posedge mclk_in) disable iff (rst_in)
        !is_master |-> allowed_queue_depth_out == 8'h00)
        else $error("target depth field not reserved");

    target_gate_a: // RQ15
    assert property (@(posedge mclk_in) disable iff (rst_in)
        tgt_op_valid_in & !enable_q |=> !tgt_op_accept_out)
        else $error("target accepted while disabled");

    master_gate_a: // RQ14
    assert property (@(posedge mclk_in) disable iff (rst_in)
        mst_op_start_out |-> $past(enable_q) && $past(mst_op_req_in) &&
        (!$past(mst_high_addr_in) || $past(high_q))) // RQ18
        else $error("master started without permission");

    dual_addr_mode_a: // RQ19
    assert property (@(posedge mclk_in) disable iff (rst_in)
        tgt_op_valid_in & enable_q & !is_master &
        tgt_op_kind_in == gpc_pkg::GPC_OP_DUAL_ADDR |=>
        tgt_op_accept_out == ($past(high_q) && !$past(sideband_q)))
        else $error("dual address acceptance wrong");

    reset_clears_a: // RQ23
    assert property (@(posedge mclk_in)
        rst_in |=> port_operation_on_out == 1'b0 && rate_select_out == 3'h0 &&
        allowed_queue_depth_out == 8'h00 && fast_write_on_out == 1'b0) // RQ22
        else $error("command word not cleared by reset");

    access_ack_a:
    assert property (@(posedge mclk_in) disable iff (rst_in)
        cfg_rd_in | cfg_wr_in |=> cfg_ack_out)
        else $error("access not acknowledged");

    idle_quiet_a: // RQ10
    assert property (@(posedge mclk_in) disable iff (rst_in)
        !(cfg_rd_in | cfg_wr_in) |=> !cfg_ack_out && cfg_rdata_out == 32'h0000_0000)
        else $error("answer without access");

    master_depth_a: // RQ11
    assert property (@(posedge mclk_in) disable iff (rst_in)
        cfg_wr_in & hit_cmd & cfg_be_in[3] & is_master |=>
        allowed_queue_depth_out == $past(cfg_wdata_in[31:24]))
        else $error("master depth not written");

    low_lane_a: // RQ22
    assert property (@(posedge mclk_in) disable iff (rst_in)
        cfg_wr_in & hit_cmd & cfg_be_in[0] |=> fast_write_on_out == $past(cfg_wdata_in[4]) &&
        high_address_on_out == $past(cfg_wdata_in[5]))
        else $error("fast write or high bit not written");

    rate_write_a: // RQ21
    assert property (@(posedge mclk_in) disable iff (rst_in)
        cfg_wr_in & hit_cmd & cfg_be_in[0] |=> rate_select_out == $past(cfg_wdata_in[2:0]))
        else $error("rate field not written");

    cmd_hold_a: // RQ17
    assert property (@(posedge mclk_in) disable iff (rst_in)
        !(cfg_wr_in & hit_cmd) |=> $stable(port_operation_on_out) &&
        $stable(sideband_on_out) && $stable(rate_select_out) && $stable(fast_write_on_out))
        else $error("command field moved without write");

    upper_with_accept_a: // RQ19
    assert property (@(posedge mclk_in) disable iff (rst_in)
        tgt_upper_addr_out |-> tgt_op_accept_out)
        else $error("upper address without accept");

    type3_mode_a: // RQ13
    assert property (@(posedge mclk_in) disable iff (rst_in)
        tgt_op_valid_in & enable_q & !is_master & tgt_op_kind_in == gpc_pkg::GPC_OP_SIDEBAND_T3
        |=> tgt_op_accept_out == $past(sideband_q))
        else $error("sideband acceptance wrong");

    type4_mode_a: // RQ19
    assert property (@(posedge mclk_in) disable iff (rst_in)
        tgt_op_valid_in & enable_q & !is_master & tgt_op_kind_in == gpc_pkg::GPC_OP_SIDEBAND_T4
        |=> tgt_op_accept_out == ($past(high_q) && $past(sideband_q)))
        else $error("type 4 acceptance wrong");

    plain_accept_a: // RQ15
    assert property (@(posedge mclk_in) disable iff (rst_in)
        tgt_op_valid_in & enable_q & !is_master & tgt_op_kind_in == gpc_pkg::GPC_OP_PLAIN
        |=> tgt_op_accept_out)
        else $error("plain operation not accepted");

    master_no_accept_a: // RQ15
    assert property (@(posedge mclk_in) disable iff (rst_in)
        is_master |-> !tgt_op_accept_out)
        else $error("master role accepted an operation");

    master_disabled_a: // RQ14
    assert property (@(posedge mclk_in) disable iff (rst_in)
        mst_op_req_in & !enable_q |=> !mst_op_start_out)
        else $error("master started while disabled");

    high_blocked_a: // RQ18
    assert property (@(posedge mclk_in) disable iff (rst_in)
        mst_op_req_in & mst_high_addr_in & !high_q |=> !mst_op_start_out)
        else $error("high address start without permission");

endmodule : gpc_cap_regs
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the graphics port capability words, target role and a master role copy
`timescale 1ns/10ps
`default_nettype none
`include "gpc_regs_map.svh"

module tb_top;
    // ----------------------------------------
    // stimulus, observed outputs, counters
    // ----------------------------------------
    localparam logic [7:0] BASE = 8'h40;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cfg_rd_in = 1'b0;
    logic cfg_wr_in = 1'b0;
    logic [7:0] cfg_addr_in = 8'h00;
    logic [3:0] cfg_be_in = 4'h0;
    logic [31:0] cfg_wdata_in = 32'h0000_0000;
    logic mst_op_req_in = 1'b0;
    logic mst_high_addr_in = 1'b0;
    logic tgt_op_valid_in = 1'b0;
    gpc_pkg::gpc_op_type tgt_op_kind_in = gpc_pkg::GPC_OP_PLAIN;
    logic cfg_ack_out, mst_op_start_out, tgt_op_accept_out, tgt_upper_addr_out;
    logic port_operation_on_out, sideband_on_out, high_address_on_out, fast_write_on_out;
    logic [2:0] rate_select_out;
    logic [7:0] allowed_queue_depth_out;
    logic [31:0] cfg_rdata_out;
    logic [31:0] rdv;
    logic [31:0] m_rdata_out;
    logic [31:0] mrdv;
    logic m_start_out;
    int miscompares = 0;
    int comparisons = 0;

    // clock of 8 ns period
    always #4 mclk_in = ~mclk_in;

    gpc_cap_regs #(.CAP_BASE(BASE)) dut (
        .mclk_in(mclk_in), .rst_in(rst_in), .cfg_rd_in(cfg_rd_in), .cfg_wr_in(cfg_wr_in),
        .cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in),
        .cfg_ack_out(cfg_ack_out), .cfg_rdata_out(cfg_rdata_out),
        .mst_op_req_in(mst_op_req_in), .mst_high_addr_in(mst_high_addr_in),
        .mst_op_start_out(mst_op_start_out), .tgt_op_valid_in(tgt_op_valid_in),
        .tgt_op_kind_in(tgt_op_kind_in), .tgt_op_accept_out(tgt_op_accept_out),
        .tgt_upper_addr_out(tgt_upper_addr_out), .port_operation_on_out(port_operation_on_out),
        .sideband_on_out(sideband_on_out), .high_address_on_out(high_address_on_out),
        .fast_write_on_out(fast_write_on_out), .rate_select_out(rate_select_out),
        .allowed_queue_depth_out(allowed_queue_depth_out));

    // master role copy on the same inputs
    gpc_cap_regs #(.ROLE(gpc_pkg::GPC_ROLE_MASTER), .CAP_BASE(BASE)) dut_mst (
        .mclk_in(mclk_in), .rst_in(rst_in), .cfg_rd_in(cfg_rd_in), .cfg_wr_in(cfg_wr_in),
        .cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in),
        .cfg_ack_out(), .cfg_rdata_out(m_rdata_out),
        .mst_op_req_in(mst_op_req_in), .mst_high_addr_in(mst_high_addr_in),
        .mst_op_start_out(m_start_out), .tgt_op_valid_in(tgt_op_valid_in),
        .tgt_op_kind_in(tgt_op_kind_in), .tgt_op_accept_out(),
        .tgt_upper_addr_out(), .port_operation_on_out(),
        .sideband_on_out(), .high_address_on_out(),
        .fast_write_on_out(), .rate_select_out(),
        .allowed_queue_depth_out());

    // ----------------------------------------
    // compare, bus and closing tasks
    // ----------------------------------------
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_word

    // one access, ack checked in the cycle after it stands
    task automatic cfg_xfer(input logic wr, input logic [7:0] off, input logic [3:0] be,
                            input logic [31:0] data);
        @(posedge mclk_in);
        cfg_rd_in <= ~wr;
        cfg_wr_in <= wr;
        cfg_addr_in <= BASE + off;
        cfg_be_in <= be;
        cfg_wdata_in <= data;
        @(posedge mclk_in);
        cfg_rd_in <= 1'b0;
        cfg_wr_in <= 1'b0;
        #1;
        chk_word({31'h0, cfg_ack_out}, 32'h1, "ack");
        rdv = cfg_rdata_out;
        mrdv = m_rdata_out;
    endtask : cfg_xfer

    // the mode outputs packed like the command word
    function automatic logic [31:0] modes();
        return {allowed_queue_depth_out, 14'h0, sideband_on_out, port_operation_on_out,
                2'h0, high_address_on_out, fast_write_on_out, 1'b0, rate_select_out};
    endfunction : modes

    task automatic wrap_up();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // identifier word fixed and unwritable
    task automatic t_ident();
        cfg_xfer(1'b0, `GPC_ID_OFF, 4'h0, 32'h0);
        chk_word(rdv, 32'h0020_0002, "id word");
        cfg_xfer(1'b1, `GPC_ID_OFF, 4'hF, 32'hFFFF_FFFF);
        cfg_xfer(1'b0, `GPC_ID_OFF, 4'h0, 32'h0);
        chk_word(rdv, 32'h0020_0002, "id after write");
    endtask : t_ident

    // status word reports support and ignores writes
    task automatic t_status();
        cfg_xfer(1'b1, `GPC_STAT_OFF, 4'hF, 32'hFFFF_FFFF);
        cfg_xfer(1'b0, `GPC_STAT_OFF, 4'h0, 32'h0);
        chk_word(rdv, 32'h1F00_0237, "status");
    endtask : t_status

    // byte lanes, enable last, reserved bits, unmapped place
    task automatic t_command();
        cfg_xfer(1'b0, `GPC_CMD_OFF, 4'h0, 32'h0);
        chk_word(rdv, 32'h0, "cmd at reset");
        cfg_xfer(1'b1, `GPC_CMD_OFF, 4'h1, 32'hFFFF_FFFF);
        chk_word(modes(), 32'h0000_0037, "low lane modes");
        cfg_xfer(1'b1, `GPC_CMD_OFF, 4'hF, 32'hFFFF_FFFF);
        chk_word(modes(), 32'h0000_0337, "full modes");
        cfg_xfer(1'b0, `GPC_CMD_OFF, 4'h0, 32'h0);
        chk_word(rdv, 32'h0000_0337, "cmd readback");
        chk_word(mrdv, 32'hFF00_0337, "master cmd readback");
        cfg_xfer(1'b0, 8'h0C, 4'h0, 32'h0);
        chk_word(rdv, 32'h0, "unmapped read");
    endtask : t_command

    // every kind under every enable, high and sideband setting
    task automatic t_target_ops();
        logic en, b5, b9, acc;
        for (int c = 0; c < 8; c++)
        begin
            en = c[0];
            b5 = c[1];
            b9 = c[2];
            cfg_xfer(1'b1, `GPC_CMD_OFF, 4'hF, {22'h0, b9, en, 2'h0, b5, 5'h01});
            for (int k = 0; k < 4; k++)
            begin
                acc = en & (k == 0 | (k == 1 & b5 & !b9) | (k == 2 & b5 & b9) | (k == 3 & b9));
                @(posedge mclk_in);
                tgt_op_valid_in <= 1'b1;
                tgt_op_kind_in <= gpc_pkg::gpc_op_type'(k[1:0]);
                mst_op_req_in <= 1'b1;
                mst_high_addr_in <= k[0];
                @(posedge mclk_in);
                tgt_op_valid_in <= 1'b0;
                mst_op_req_in <= 1'b0;
                #1;
                chk_word({29'h0, tgt_op_accept_out, tgt_upper_addr_out, mst_op_start_out},
                         {29'h0, acc, acc & k == 3 & b5, 1'b0}, "target op");
                chk_word({31'h0, m_start_out}, {31'h0, en & (!k[0] | b5)}, "master start");
            end
        end
    endtask : t_target_ops

    // second reset clears a programmed command word
    task automatic t_rereset();
        cfg_xfer(1'b1, `GPC_CMD_OFF, 4'hF, 32'hFFFF_FFFF);
        @(posedge mclk_in);
        rst_in <= 1'b1;
        @(posedge mclk_in);
        rst_in <= 1'b0;
        #1;
        chk_word(modes(), 32'h0, "modes after reset");
        cfg_xfer(1'b0, `GPC_CMD_OFF, 4'h0, 32'h0);
        chk_word(rdv, 32'h0, "cmd after reset");
    endtask : t_rereset

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_ident();
        t_status();
        t_command();
        t_target_ops();
        t_rereset();
        wrap_up();
    end

    initial
    begin
        #20000;
        miscompares++;
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
